/* pkg/iosfs_pkg.sv */
/*
 iosfs_pkg: constants, operation codes, states and carriers of the io space, flag word and stack block.
 assumes one core clock shared with the execution core, the data ram and the peripheral registers.
*/
package iosfs_pkg;
	// io window and its alias in data space
	localparam logic [5:0] BIT_IO_LAST     = 6'h1f;
	localparam logic [7:0] DATA_IO_BASE    = 8'h20;
	localparam logic [7:0] DATA_IO_LAST    = 8'h5f;
	localparam logic [5:0] ADDR_STACK_PTR  = 6'h3d;
	localparam logic [5:0] ADDR_FLAG_WORD  = 6'h3f;
	// stack ram region
	localparam logic [7:0] STACK_RAM_FIRST = 8'h60;
	localparam logic [7:0] STACK_RAM_LAST  = 8'hdf;
	localparam logic [7:0] STK_STEP_BYTE   = 8'h01;
	localparam logic [7:0] STK_STEP_ADDR   = 8'h02;
	// values after reset
	localparam logic [7:0] RST_STACK_PTR   = 8'h00;
	localparam logic [7:0] RST_FLAG_WORD   = 8'h00;
	// flag word bit positions
	localparam logic [2:0] FLG_GIE  = 3'h7;
	localparam logic [2:0] FLG_T    = 3'h6;
	localparam logic [2:0] FLG_H    = 3'h5;
	localparam logic [2:0] FLG_S    = 3'h4;
	localparam logic [2:0] FLG_V    = 3'h3;
	localparam logic [2:0] FLG_N    = 3'h2;
	localparam logic [2:0] FLG_Z    = 3'h1;
	localparam logic [2:0] FLG_C    = 3'h0;

	typedef enum logic [4:0] {
		OP_IO_RD    = 5'h00,
		OP_IO_WR    = 5'h01,
		OP_DATA_RD  = 5'h02,
		OP_DATA_WR  = 5'h03,
		OP_BIT_SET  = 5'h04,
		OP_BIT_CLR  = 5'h05,
		OP_SKIP_ONE = 5'h06,
		OP_SKIP_ZRO = 5'h07,
		OP_ALU      = 5'h08,
		OP_T_STORE  = 5'h09,
		OP_T_LOAD   = 5'h0a,
		OP_PUSH     = 5'h0b,
		OP_POP      = 5'h0c,
		OP_CALL     = 5'h0d,
		OP_RET      = 5'h0e,
		OP_IRQ      = 5'h0f,
		OP_IRQ_RET  = 5'h10
	} iosfs_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RD   = 2'h1,
		ST_CAP  = 2'h2,
		ST_WR2  = 2'h3
	} iosfs_fsm_t;

	// alu mask and flag order: [4] half carry, [3] overflow, [2] negative, [1] zero, [0] carry
	typedef struct packed {
		logic       valid;
		iosfs_op_t  op;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] wdata_hi;
		logic [2:0] bit_sel;
		logic [4:0] alu_mask;
		logic [4:0] alu_flags;
	} iosfs_req_t;

	typedef struct packed {
		logic       done;
		logic       reject;
		logic       skip;
		logic [7:0] rdata;
		logic [7:0] rdata_hi;
	} iosfs_rsp_t;

	typedef struct packed {
		logic       valid;
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} iosfs_bus_t;

	typedef struct packed {
		iosfs_fsm_t fsm;
		iosfs_op_t  op;
		logic       second;
		logic [2:0] bit_sel;
		logic [7:0] wdata_hi;
		logic [7:0] flag;
		logic [7:0] stk;
		logic       ready;
		iosfs_rsp_t rsp;
		iosfs_bus_t mem;
		iosfs_bus_t per;
	} iosfs_state_t;
endpackage

/* hw/iosfs_core.sv */
/*
 iosfs_core: io window decode, bit access with read-modify-write, flag word and stack pointer.
 assumes the execution core waits for ready_q, and that data ram and peripheral registers
 return read data in the cycle after they see a read strobe.
*/
// Contract
// - io instructions use six bit io address
// - data address equals io address plus 20
// - bit operations only below io address 20
// - some flags clear on writing one
// - bit set/clear rewrite whole register
// - global gate zero blocks every interrupt
// - accept clears gate, interrupt return sets it
// - bit six is copy scratch bit
// - bit five holds half carry
// - bit four equals negative xor overflow
// - bit two negative, bit one zero
// - bit three overflow, bit zero carry
// - flag word never saved on interrupt
// - stack pointer at 3d, resets zero
// - byte push decrements, pop increments, by one
// - return address moves pointer by two
`timescale 1ns/1ps
module iosfs_core
	import iosfs_pkg::*;
(
	// clock, reset, enable
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	// execution core
	input  wire iosfs_req_t req,
	output logic            ready_q,
	output iosfs_rsp_t      rsp_q,
	output logic [7:0]      flag_word_q,
	output logic [7:0]      stack_ptr_q,
	// data ram for the stack
	output iosfs_bus_t      mem_q,
	input  wire logic [7:0] mem_rdata,
	// peripheral io registers
	output iosfs_bus_t      per_q,
	input  wire logic [7:0] per_rdata
);
	iosfs_state_t s;
	iosfs_state_t n;
	logic         take;

	assign take        = req.valid && s.ready;
	assign ready_q     = s.ready;
	assign rsp_q       = s.rsp;
	assign flag_word_q = s.flag;
	assign stack_ptr_q = s.stk;
	assign mem_q       = s.mem;
	assign per_q       = s.per;

	// sign bit is never stored as written, so it cannot drift from n and v
	function automatic logic [7:0] fix_sign(input logic [7:0] f);
		logic [7:0] r;
		r = f;
		r[FLG_S] = f[FLG_N] ^ f[FLG_V];
		return r;
	endfunction

	always_comb begin
		logic [7:0] doff;
		logic [5:0] ioa;
		logic       win_ok;
		logic [7:0] data;
		logic [7:0] bmask;
		logic [7:0] f;
		doff   = req.addr - DATA_IO_BASE;
		win_ok = 1'b1;
		ioa    = req.addr[5:0];
		data   = (s.op == OP_POP || s.op == OP_RET || s.op == OP_IRQ_RET) ? mem_rdata : per_rdata;
		bmask  = 8'h01 << s.bit_sel;
		f      = s.flag;
		n = s;
		n.mem.valid  = 1'b0;
		n.per.valid  = 1'b0;
		n.rsp.done   = 1'b0;
		n.rsp.reject = 1'b0;
		n.rsp.skip   = 1'b0;
		if (req.op == OP_DATA_RD || req.op == OP_DATA_WR) begin
			win_ok = (req.addr >= DATA_IO_BASE) && (req.addr <= DATA_IO_LAST);
			ioa    = doff[5:0];
		end
		case (s.fsm)
			ST_IDLE: begin
				if (take) begin
					n.op       = req.op;
					n.bit_sel  = req.bit_sel;
					n.wdata_hi = req.wdata_hi;
					n.second   = 1'b0;
					n.per.addr = {2'h0, ioa};
					n.per.we   = 1'b0;
					n.rsp.done = 1'b1;
					case (req.op)
						OP_IO_RD, OP_DATA_RD: begin
							if (!win_ok) begin
								n.rsp.reject = 1'b1;
							end else if (ioa == ADDR_FLAG_WORD) begin
								n.rsp.rdata = s.flag;
							end else if (ioa == ADDR_STACK_PTR) begin
								n.rsp.rdata = s.stk;
							end else begin
								n.rsp.done  = 1'b0;
								n.per.valid = 1'b1;
								n.fsm       = ST_RD;
							end
						end
						OP_IO_WR, OP_DATA_WR: begin
							if (!win_ok) begin
								n.rsp.reject = 1'b1;
							end else if (ioa == ADDR_FLAG_WORD) begin
								n.flag = fix_sign(req.wdata);
							end else if (ioa == ADDR_STACK_PTR) begin
								n.stk = req.wdata;
							end else begin
								// w1c flags live in the peripherals; the write is passed on as given
								n.per.valid = 1'b1;
								n.per.we    = 1'b1;
								n.per.wdata = req.wdata;
							end
						end
						OP_BIT_SET, OP_BIT_CLR, OP_SKIP_ONE, OP_SKIP_ZRO: begin
							if (req.addr[5:0] > BIT_IO_LAST) begin
								n.rsp.reject = 1'b1;
							end else begin
								n.rsp.done  = 1'b0;
								n.per.valid = 1'b1;
								n.fsm       = ST_RD;
							end
						end
						OP_ALU: begin
							if (req.alu_mask[4]) f[FLG_H] = req.alu_flags[4];
							if (req.alu_mask[3]) f[FLG_V] = req.alu_flags[3];
							if (req.alu_mask[2]) f[FLG_N] = req.alu_flags[2];
							if (req.alu_mask[1]) f[FLG_Z] = req.alu_flags[1];
							if (req.alu_mask[0]) f[FLG_C] = req.alu_flags[0];
							n.flag = fix_sign(f);
						end
						OP_T_STORE: begin
							n.flag[FLG_T] = req.wdata[req.bit_sel];
						end
						OP_T_LOAD: begin
							n.rsp.rdata = req.wdata;
							n.rsp.rdata[req.bit_sel] = s.flag[FLG_T];
						end
						OP_PUSH: begin
							n.mem.valid = 1'b1;
							n.mem.we    = 1'b1;
							n.mem.addr  = s.stk;
							n.mem.wdata = req.wdata;
							n.stk       = s.stk - STK_STEP_BYTE;
						end
						OP_POP, OP_RET, OP_IRQ_RET: begin
							n.rsp.done  = 1'b0;
							n.mem.valid = 1'b1;
							n.mem.we    = 1'b0;
							n.mem.addr  = s.stk + STK_STEP_BYTE;
							n.fsm       = ST_RD;
						end
						OP_CALL, OP_IRQ: begin
							if (req.op == OP_IRQ && !s.flag[FLG_GIE]) begin
								n.rsp.reject = 1'b1;
							end else begin
								// the flag word is not pushed, only its gate is cleared on an interrupt; handlers save it themselves
								if (req.op == OP_IRQ) n.flag[FLG_GIE] = 1'b0;
								n.rsp.done  = 1'b0;
								n.mem.valid = 1'b1;
								n.mem.we    = 1'b1;
								n.mem.addr  = s.stk;
								n.mem.wdata = req.wdata;
								n.fsm       = ST_WR2;
							end
						end
						default: begin
							n.rsp.reject = 1'b1;
						end
					endcase
				end
			end
			ST_RD: begin
				n.fsm = ST_CAP;
			end
			ST_CAP: begin
				n.fsm      = ST_IDLE;
				n.rsp.done = 1'b1;
				case (s.op)
					OP_BIT_SET, OP_BIT_CLR: begin
						// whole register goes back, so any w1c flag read as one is cleared, except the bit that a bit clear targets
						n.per.valid = 1'b1;
						n.per.we    = 1'b1;
						n.per.wdata = (s.op == OP_BIT_SET) ? (data | bmask) : (data & ~bmask);
					end
					OP_SKIP_ONE: begin
						n.rsp.skip = (data & bmask) != 8'h00;
					end
					OP_SKIP_ZRO: begin
						n.rsp.skip = (data & bmask) == 8'h00;
					end
					OP_POP: begin
						n.rsp.rdata = data;
						n.stk       = s.stk + STK_STEP_BYTE;
					end
					OP_RET, OP_IRQ_RET: begin
						if (!s.second) begin
							n.rsp.done     = 1'b0;
							n.rsp.rdata_hi = data;
							n.second       = 1'b1;
							n.mem.valid    = 1'b1;
							n.mem.we       = 1'b0;
							n.mem.addr     = s.stk + STK_STEP_ADDR;
							n.fsm          = ST_RD;
						end else begin
							n.rsp.rdata = data;
							n.stk       = s.stk + STK_STEP_ADDR;
							if (s.op == OP_IRQ_RET) n.flag[FLG_GIE] = 1'b1;
						end
					end
					default: begin
						n.rsp.rdata = data;
					end
				endcase
			end
			ST_WR2: begin
				n.fsm       = ST_IDLE;
				n.rsp.done  = 1'b1;
				n.mem.valid = 1'b1;
				n.mem.we    = 1'b1;
				n.mem.addr  = s.stk - STK_STEP_BYTE;
				n.mem.wdata = s.wdata_hi;
				n.stk       = s.stk - STK_STEP_ADDR;
			end
			default: begin
				n.fsm = ST_IDLE;
			end
		endcase
		n.ready = (n.fsm == ST_IDLE);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s       <= '0;
			s.ready <= 1'b1;
			s.stk   <= RST_STACK_PTR;
			s.flag  <= RST_FLAG_WORD;
		end else if (clk_en) begin
			s <= n;
		end
	end

	default clocking cb @(posedge core_clk iff clk_en); endclocking
	default disable iff (sys_rst);

	sequence call_first_write;
		mem_q.valid && mem_q.we && mem_q.addr == $past(stack_ptr_q);
	endsequence
	sequence call_second_write;
		mem_q.valid && mem_q.we && mem_q.addr == $past(stack_ptr_q, 2) - STK_STEP_BYTE
			&& stack_ptr_q == $past(stack_ptr_q, 2) - STK_STEP_ADDR;
	endsequence

	chk_flag_read: assert property (take && req.op == OP_IO_RD && req.addr[5:0] == ADDR_FLAG_WORD
		|=> rsp_q.done && rsp_q.rdata == $past(flag_word_q)) else $error("flag word read wrong");
	chk_data_alias: assert property (take && req.op == OP_DATA_WR && req.addr == 8'h5d
		|=> stack_ptr_q == $past(req.wdata)) else $error("aliased stack pointer write lost");
	chk_bit_reject: assert property (take && req.op == OP_BIT_SET && req.addr[5:0] > BIT_IO_LAST
		|=> rsp_q.reject && rsp_q.done && !per_q.valid) else $error("high bit access not refused");
	chk_rmw_writeback: assert property (take && req.op == OP_BIT_SET && req.addr[5:0] <= BIT_IO_LAST
		|=> (per_q.valid && !per_q.we) ##1 1'b1 ##1 (per_q.valid && per_q.we && rsp_q.done
		&& per_q.wdata == ($past(per_rdata) | (8'h01 << $past(req.bit_sel, 3)))))
		else $error("bit set write back wrong");
	chk_clear_keeps_ones: assert property (take && req.op == OP_BIT_CLR && req.addr[5:0] <= BIT_IO_LAST
		|=> ##2 per_q.we && per_q.wdata == ($past(per_rdata) & ~(8'h01 << $past(req.bit_sel, 3))))
		else $error("bit clear lost other set flags");
	chk_gate_blocks: assert property (take && req.op == OP_IRQ && !flag_word_q[FLG_GIE]
		|=> rsp_q.reject && !mem_q.valid) else $error("interrupt taken with gate closed");
	chk_gate_clear: assert property (take && req.op == OP_IRQ && flag_word_q[FLG_GIE]
		|=> !flag_word_q[FLG_GIE] ##1 rsp_q.done) else $error("gate not cleared on accept");
	chk_bit_store: assert property (take && req.op == OP_T_STORE
		|=> flag_word_q[FLG_T] == $past(req.wdata[req.bit_sel])) else $error("scratch bit not stored");
	chk_sign_bit: assert property (flag_word_q[FLG_S] == (flag_word_q[FLG_N] ^ flag_word_q[FLG_V]))
		else $error("sign bit differs from n xor v");
	chk_alu_flags: assert property (take && req.op == OP_ALU && req.alu_mask == 5'h1f
		|=> {flag_word_q[FLG_H], flag_word_q[FLG_V], flag_word_q[FLG_N], flag_word_q[FLG_Z],
		flag_word_q[FLG_C]} == $past(req.alu_flags)) else $error("alu flags not taken");
	chk_sp_reset: assert property (@(posedge core_clk) disable iff (1'b0) sys_rst
		|=> stack_ptr_q == RST_STACK_PTR) else $error("stack pointer not reset");
	chk_push_step: assert property (take && req.op == OP_PUSH |=> mem_q.valid && mem_q.we
		&& mem_q.addr == $past(stack_ptr_q) && stack_ptr_q == $past(stack_ptr_q) - STK_STEP_BYTE)
		else $error("push step wrong");
	chk_call_step: assert property (take && req.op == OP_CALL
		|=> call_first_write ##1 call_second_write) else $error("call step wrong");
	chk_pop_order: assert property (take && req.op == OP_POP
		|=> (mem_q.valid && !mem_q.we && mem_q.addr == $past(stack_ptr_q) + STK_STEP_BYTE) ##1 1'b1
		##1 (rsp_q.done && stack_ptr_q == $past(stack_ptr_q, 3) + STK_STEP_BYTE)) else $error("pop order wrong");
endmodule

/* bench/iosfs_mem_model.sv */
/*
 iosfs_mem_model: stack ram and peripheral io registers behind the block.
 assumes registered strobes; read data is returned in the cycle after the strobe.
*/
`timescale 1ns/1ps
module iosfs_mem_model
	import iosfs_pkg::*;
(
	// clock
	input  wire logic       core_clk,
	// strobes from the block
	input  wire iosfs_bus_t mem_q,
	input  wire iosfs_bus_t per_q,
	// read data
	output logic [7:0]      mem_rdata,
	output logic [7:0]      per_rdata
);
	logic [7:0] ram [256];
	logic [7:0] per [64];

	initial begin
		foreach (ram[i]) ram[i] = 8'(i);
		foreach (per[i]) per[i] = 8'h80;
	end

	// lines toggle outside the answer cycle so a late sample is caught
	always @(posedge core_clk) begin
		mem_rdata <= (mem_q.valid && !mem_q.we) ? ram[mem_q.addr] : ~mem_rdata;
		per_rdata <= (per_q.valid && !per_q.we) ? per[per_q.addr[5:0]] : ~per_rdata;
		if (mem_q.valid && mem_q.we) begin
			ram[mem_q.addr] <= mem_q.wdata;
		end
		if (per_q.valid && per_q.we) begin
			// io 0b: top bit is a status flag cleared by writing one
			if (per_q.addr == 8'h0b) begin
				per[11] <= (per[11] & ~per_q.wdata & 8'h80) | (per_q.wdata & 8'h7f);
			end else begin
				per[per_q.addr[5:0]] <= per_q.wdata;
			end
		end
	end
endmodule

/* bench/test_io_space_flags_stack.sv */
/*
 test_io_space_flags_stack: self-checking bench acting as the execution core.
 assumes iosfs_mem_model answers for stack ram and peripheral registers.
*/
`timescale 1ns/1ps
module test_io_space_flags_stack
	import iosfs_pkg::*;
;
	logic        core_clk;
	logic        sys_rst;
	logic        clk_en;
	iosfs_req_t  req;
	logic        ready_q;
	iosfs_rsp_t  rsp_q;
	iosfs_rsp_t  got;
	logic [7:0]  flag_word_q;
	logic [7:0]  stack_ptr_q;
	iosfs_bus_t  mem_q;
	iosfs_bus_t  per_q;
	logic [7:0]  mem_rdata;
	logic [7:0]  per_rdata;
	int          mismatches;
	int          checks_done;
	logic [31:0] seed;
	logic [15:0] last_pw;
	logic [15:0] last_mw;
	logic [7:0]  last_ma;

	iosfs_core i_dut (
		.core_clk    (core_clk),
		.sys_rst     (sys_rst),
		.clk_en      (clk_en),
		.req         (req),
		.ready_q     (ready_q),
		.rsp_q       (rsp_q),
		.flag_word_q (flag_word_q),
		.stack_ptr_q (stack_ptr_q),
		.mem_q       (mem_q),
		.mem_rdata   (mem_rdata),
		.per_q       (per_q),
		.per_rdata   (per_rdata)
	);

	iosfs_mem_model i_mem (
		.core_clk  (core_clk),
		.mem_q     (mem_q),
		.per_q     (per_q),
		.mem_rdata (mem_rdata),
		.per_rdata (per_rdata)
	);

	always @(posedge core_clk) begin
		if (per_q.valid && per_q.we) begin
			last_pw <= {per_q.addr, per_q.wdata};
		end
		if (mem_q.valid && mem_q.we) begin
			last_mw <= {last_mw[7:0], mem_q.wdata};
			last_ma <= mem_q.addr;
		end
	end

	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	// masked alu flags land in h,v,n,z,c; sign is always rebuilt
	function automatic logic [7:0] alu_exp(logic [7:0] f, logic [4:0] m, logic [4:0] v);
		logic [7:0] m8;
		logic [7:0] v8;
		m8 = {2'b00, m[4], 1'b0, m[3:0]};
		v8 = {2'b00, v[4], 1'b0, v[3:0]};
		f = (f & ~m8) | (v8 & m8);
		f[4] = f[2] ^ f[3];
		return f;
	endfunction

	function automatic iosfs_req_t mk(iosfs_op_t op, logic [7:0] a, logic [7:0] d = 8'h00,
		logic [7:0] h = 8'h00, logic [2:0] b = 3'h0, logic [4:0] m = 5'h00, logic [4:0] v = 5'h00);
		return '{1'b1, op, a, d, h, b, m, v};
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// request held until the accepting edge, then answer awaited under a bound
	task automatic run(input iosfs_req_t r);
		int n;
		n = 0;
		@(posedge core_clk);
		req <= r;
		@(posedge core_clk);
		req.valid <= 1'b0;
		do begin
			@(negedge core_clk);
			n++;
		end while (rsp_q.done !== 1'b1 && n < 12);
		if (n >= 12) begin
			mismatches++;
			$display("mismatch at %0t: no answer", $time);
		end
		got = rsp_q;
		@(posedge core_clk);
		#1;
	endtask

	task automatic final_report();
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	initial begin
		#20000;
		mismatches++;
		final_report();
	end

	initial begin
		logic [7:0] a;
		logic [7:0] v;
		logic [7:0] f;
		logic [7:0] e;
		logic [2:0] b;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		req = '0;
		seed = 32'd21;
		mismatches = 0;
		checks_done = 0;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1;
		chk(stack_ptr_q, RST_STACK_PTR);
		v = xs();
		run(mk(OP_IO_WR, 8'h3d, v));
		chk(stack_ptr_q, v);
		run(mk(OP_DATA_RD, 8'h5d));
		chk(got.rdata, v);
		run(mk(OP_DATA_WR, 8'h5d, ~v));
		chk(stack_ptr_q, ~v);
		run(mk(OP_DATA_RD, 8'h1f));
		chk(8'(got.reject), 8'h01);
		run(mk(OP_DATA_WR, 8'h60, v));
		chk(8'(got.reject), 8'h01);
		// mask keeps clear of 0b, 3d and 3f
		for (int i = 0; i < 10; i++) begin
			a = xs() & 8'h37;
			v = xs();
			run(mk(OP_IO_WR, a, v));
			chk(last_pw[15:8], a);
			chk(last_pw[7:0], v);
			run(mk(OP_DATA_RD, a + DATA_IO_BASE));
			chk(got.rdata, v);
		end
		for (int k = 0; k < 4; k++) begin
			v = xs();
			b = v[6:4];
			run(mk(OP_IO_WR, 8'h1f, v));
			run(mk(iosfs_op_t'(5'h04 + 5'(k)), 8'h1f, 8'h00, 8'h00, b));
			case (k)
				0: chk(last_pw[7:0], v | (8'h01 << b));
				1: chk(last_pw[7:0], v & ~(8'h01 << b));
				2: chk(8'(got.skip), 8'(v[b]));
				default: chk(8'(got.skip), 8'(!v[b]));
			endcase
			run(mk(iosfs_op_t'(5'h04 + 5'(k)), 8'h20));
			chk(8'(got.reject), 8'h01);
		end
		run(mk(OP_IO_WR, 8'h0b, 8'h04));
		run(mk(OP_BIT_SET, 8'h0b));
		chk(last_pw[7:0], 8'h85);
		run(mk(OP_IO_RD, 8'h0b));
		chk(got.rdata, 8'h05);
		run(mk(OP_IO_WR, 8'h3f, 8'h7f));
		f = alu_exp(8'h7f, 5'h00, 5'h00);
		chk(flag_word_q, f);
		run(mk(OP_IO_RD, 8'h3f));
		chk(got.rdata, f);
		run(mk(OP_IRQ, 8'h00));
		chk(8'(got.reject), 8'h01);
		for (int i = 0; i < 8; i++) begin
			v = xs();
			if (i == 0) v[4:0] = 5'h1f;
			e = xs();
			f = alu_exp(f, v[4:0], e[4:0]);
			run(mk(OP_ALU, 8'h00, 8'h00, 8'h00, 3'h0, v[4:0], e[4:0]));
			chk(flag_word_q, f);
			v = xs();
			b = e[7:5];
			f[6] = v[b];
			run(mk(OP_T_STORE, 8'h00, v, 8'h00, b));
			chk(flag_word_q, f);
			e = ~v;
			e[b] = f[6];
			run(mk(OP_T_LOAD, 8'h00, ~v, 8'h00, b));
			chk(got.rdata, e);
		end
		// stack placed inside ram before any call or interrupt
		run(mk(OP_IO_WR, 8'h3d, 8'ha0));
		f[7] = 1'b1;
		run(mk(OP_IO_WR, 8'h3f, f));
		v = xs();
		e = xs();
		run(mk(OP_IRQ, 8'h00, v, e));
		chk(flag_word_q, f & 8'h7f);
		chk(stack_ptr_q, 8'h9e);
		chk(last_ma, 8'h9f);
		chk(last_mw[7:0], e);
		chk(last_mw[15:8], v);
		run(mk(OP_IRQ, 8'h00));
		chk(8'(got.reject), 8'h01);
		run(mk(OP_IRQ_RET, 8'h00));
		chk(got.rdata, v);
		chk(got.rdata_hi, e);
		chk(flag_word_q, f);
		chk(stack_ptr_q, 8'ha0);
		v = xs();
		run(mk(OP_PUSH, 8'h00, v));
		chk(last_ma, 8'ha0);
		chk(stack_ptr_q, 8'h9f);
		run(mk(OP_CALL, 8'h00, e, v));
		chk(stack_ptr_q, 8'h9d);
		run(mk(OP_RET, 8'h00));
		chk(got.rdata, e);
		chk(stack_ptr_q, 8'h9f);
		// enable drops mid pop; nothing may move until it returns
		fork
			run(mk(OP_POP, 8'h00));
			begin
				repeat (2) @(posedge core_clk);
				clk_en <= 1'b0;
				repeat (2) @(posedge core_clk);
				#1;
				chk(8'(ready_q), 8'h00);
				chk(stack_ptr_q, 8'h9f);
				repeat (2) @(posedge core_clk);
				clk_en <= 1'b1;
			end
		join
		chk(got.rdata, v);
		chk(stack_ptr_q, 8'ha0);
		final_report();
	end
endmodule
